// ### hw/psf_pkg.sv
/*
 * psf_pkg: constants and types for the per-port special function register.
 * assumes a single clk_sys domain and a synchronous active-high reset.
 */
// Notes on behaviour
// - a two-bit field in bits 11:10 picks transmit rise time 3.3, 3.6, 3.9 or 4.2 ns for codes 00 to 11.
// - at hardware reset the rise-time field is loaded from the slew configuration pins.
// - bit 9 turns automatic crossover on when set and off when clear, and resets to one.
// - bit 8 selects straight pairs (transmit on A) at zero and crossed pairs (transmit on B) at one, reset one.
// - bit 7 loops transmit back into the receiver on the twisted-pair side, reset zero.
// - bits 6 and 5 enable loopback detection and its speed-up, both reset zero.
// - bit 4 reads one while a loopback condition is detected, reset zero.
`default_nettype none

package psf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0]  SFC_ADDR       = 5'h1b;
    localparam int          LEN_LSB        = 13;
    localparam int          RSV_HI_BIT     = 12;
    localparam int          SLEW_LSB       = 10;
    localparam int          XOVER_EN_BIT   = 9;
    localparam int          XOVER_SEL_BIT  = 8;
    localparam int          ALOOP_BIT      = 7;
    localparam int          LBDET_EN_BIT   = 6;
    localparam int          LBSPD_EN_BIT   = 5;
    localparam int          LBDET_BIT      = 4;
    localparam logic        XOVER_EN_RST   = 1'h1;
    localparam logic        XOVER_SEL_RST  = 1'h1;
    localparam logic        ALOOP_RST      = 1'h0;
    localparam logic        LBDET_EN_RST   = 1'h0;
    localparam logic        LBSPD_EN_RST   = 1'h0;
    localparam logic [2:0]  LEN_RST        = 3'h0;
    localparam logic [3:0]  RSV_LO_RST     = 4'h0;
    localparam logic        RSV_HI_RST     = 1'h0;

    // ------------------------------------------------------------
    // rise time codes, in tenths of a nanosecond
    // ------------------------------------------------------------
    localparam logic [5:0]  RISE_00_DNS    = 6'h21;
    localparam logic [5:0]  RISE_01_DNS    = 6'h24;
    localparam logic [5:0]  RISE_10_DNS    = 6'h27;
    localparam logic [5:0]  RISE_11_DNS    = 6'h2a;

    typedef struct packed {
        logic [1:0] rise_sel;
        logic       xover_en;
        logic       xover_sel;
        logic       analog_loop;
        logic       lb_detect_en;
        logic       lb_speedup_en;
        logic       rsv_hi;
        logic [3:0] rsv_lo;
    } psf_ctrl_t;

    typedef struct packed {
        logic [2:0] line_len;
        logic       lb_detected;
        logic       xover_auto_sel;
    } psf_stat_t;

endpackage : psf_pkg

`default_nettype wire

// ### hw/psf_sync.sv
/*
 * psf_sync: two-flop synchroniser for pin-level inputs.
 * assumes inputs are quasi-static levels from outside clk_sys.
 */
`default_nettype none

module psf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = din;
        sync_nxt = meta_r;
    end

    // no reset on these flops: strap pins must already be through both
    // stages when reset releases, so they keep sampling while rst is high
    always_ff @(posedge clk_sys) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign dout = sync_r;
endmodule : psf_sync

`default_nettype wire

// ### hw/psf_reg.sv
/*
 * psf_reg: per-port special function control and status register.
 * assumes a management master on clk_sys using address/strobe ports, and
 * analog and loopback-detection status coming from pins of other logic domains.
 */
// The strobed register port was decided locally.
`default_nettype none

module psf_reg (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [1:0]  slew_config_pins,
    input  wire logic [2:0]  line_len_in,
    input  wire logic        lb_detected_in,
    input  wire logic        xover_auto_in,
    output logic      [1:0]  rise_sel,
    output logic      [5:0]  rise_time_dns,
    output logic             auto_crossover_enable,
    output logic             crossover_select,
    output logic             analog_loopback,
    output logic             lb_detect_enable,
    output logic             lb_speedup_enable
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    psf_pkg::psf_stat_t stat_s;
    logic [1:0]         slew_s;

    psf_sync #(.W(7)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     ({line_len_in, lb_detected_in, xover_auto_in, slew_config_pins}),
        .dout    ({stat_s, slew_s})
    );

    function automatic logic [5:0] rise_dns(input logic [1:0] code);
        case (code)
            2'h0:    rise_dns = psf_pkg::RISE_00_DNS;
            2'h1:    rise_dns = psf_pkg::RISE_01_DNS;
            2'h2:    rise_dns = psf_pkg::RISE_10_DNS;
            default: rise_dns = psf_pkg::RISE_11_DNS;
        endcase
    endfunction : rise_dns

    // ------------------------------------------------------------
    // strap capture: pins settle through the synchroniser while reset
    // is held, so the field is taken on the first edge after release
    // ------------------------------------------------------------
    logic strap_pend_r;
    logic strap_pend_nxt;

    psf_pkg::psf_ctrl_t ctrl_r;
    psf_pkg::psf_ctrl_t ctrl_nxt;
    psf_pkg::psf_stat_t stat_r;
    psf_pkg::psf_stat_t stat_nxt;
    logic [15:0]        rdata_r;
    logic [15:0]        rdata_nxt;
    logic               wr_hit;

    always_comb begin
        wr_hit         = reg_wr && (reg_addr == psf_pkg::SFC_ADDR);
        strap_pend_nxt = 1'b0;
        ctrl_nxt       = ctrl_r;
        stat_nxt       = stat_s;
        if (wr_hit) begin
            ctrl_nxt.rise_sel      = reg_wdata[psf_pkg::SLEW_LSB +: 2];
            ctrl_nxt.xover_en      = reg_wdata[psf_pkg::XOVER_EN_BIT];
            ctrl_nxt.xover_sel     = reg_wdata[psf_pkg::XOVER_SEL_BIT];
            ctrl_nxt.analog_loop   = reg_wdata[psf_pkg::ALOOP_BIT];
            ctrl_nxt.lb_detect_en  = reg_wdata[psf_pkg::LBDET_EN_BIT];
            ctrl_nxt.lb_speedup_en = reg_wdata[psf_pkg::LBSPD_EN_BIT];
            ctrl_nxt.rsv_hi        = reg_wdata[psf_pkg::RSV_HI_BIT];
            ctrl_nxt.rsv_lo        = reg_wdata[3:0];
        end else if (ctrl_r.xover_en) begin
            // the automatic choice overwrites the select so reads show live pairing
            ctrl_nxt.xover_sel = stat_r.xover_auto_sel;
        end
        if (strap_pend_r) begin
            ctrl_nxt.rise_sel = slew_s;
        end
        rdata_nxt = 16'h0000;
        if (reg_rd && (reg_addr == psf_pkg::SFC_ADDR)) begin
            rdata_nxt = {stat_r.line_len, ctrl_r.rsv_hi, ctrl_r.rise_sel,
                         ctrl_r.xover_en, ctrl_r.xover_sel, ctrl_r.analog_loop,
                         ctrl_r.lb_detect_en, ctrl_r.lb_speedup_en,
                         stat_r.lb_detected, ctrl_r.rsv_lo};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strap_pend_r          <= 1'b1;
            ctrl_r.rise_sel       <= 2'h0;
            ctrl_r.xover_en       <= psf_pkg::XOVER_EN_RST;
            ctrl_r.xover_sel      <= psf_pkg::XOVER_SEL_RST;
            ctrl_r.analog_loop    <= psf_pkg::ALOOP_RST;
            ctrl_r.lb_detect_en   <= psf_pkg::LBDET_EN_RST;
            ctrl_r.lb_speedup_en  <= psf_pkg::LBSPD_EN_RST;
            ctrl_r.rsv_hi         <= psf_pkg::RSV_HI_RST;
            ctrl_r.rsv_lo         <= psf_pkg::RSV_LO_RST;
            stat_r.line_len       <= psf_pkg::LEN_RST;
            stat_r.lb_detected    <= 1'b0;
            stat_r.xover_auto_sel <= 1'b0;
            rdata_r               <= 16'h0000;
        end else begin
            strap_pend_r <= strap_pend_nxt;
            ctrl_r       <= ctrl_nxt;
            stat_r       <= stat_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata             = rdata_r;
    assign rise_sel              = ctrl_r.rise_sel;
    assign rise_time_dns         = rise_dns(ctrl_r.rise_sel);
    assign auto_crossover_enable = ctrl_r.xover_en;
    assign crossover_select      = ctrl_r.xover_sel;
    assign analog_loopback       = ctrl_r.analog_loop;
    assign lb_detect_enable      = ctrl_r.lb_detect_en;
    assign lb_speedup_enable     = ctrl_r.lb_speedup_en;
endmodule : psf_reg

`default_nettype wire

// ### verification/psf_reg_checker.sv
/* psf_reg_checker: port-level checks on the special function register.
   assumes one clk_sys domain with synchronous active-high rst; bound from tb_top. */
`default_nettype none
module psf_reg_checker (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic [1:0]  slew_config_pins,
    input  wire logic [1:0]  rise_sel,
    input  wire logic [2:0]  line_len_in,
    input  wire logic        lb_detected_in,
    input  wire logic        xover_auto_in,
    input  wire logic        auto_crossover_enable,
    input  wire logic        crossover_select,
    input  wire logic        analog_loopback,
    input  wire logic        lb_detect_enable,
    input  wire logic        lb_speedup_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] wdata_r;
    logic        wr_hit;
    assign wr_hit = reg_wr && reg_addr == psf_pkg::SFC_ADDR;
    always_ff @(posedge clk_sys) wdata_r <= reg_wdata;
    sequence s_read_done;
        $past(reg_rd) && $past(reg_addr) == psf_pkg::SFC_ADDR;
    endsequence
    // status pins must settle through two sync flops and a status flop
    sequence s_pins_steady;
        $stable({line_len_in, lb_detected_in})[*6];
    endsequence
    sequence s_auto_steady;
        (auto_crossover_enable && !reg_wr && $stable(xover_auto_in))[*4];
    endsequence
    chk_rdata_idle: assert property (!($past(reg_rd) && $past(reg_addr) == psf_pkg::SFC_ADDR)
        |-> reg_rdata == 16'h0000) else $error("read data outside read slot");
    chk_ctrl_read: assert property (s_read_done |-> reg_rdata[11:5] == $past({rise_sel,
        auto_crossover_enable, crossover_select, analog_loopback, lb_detect_enable,
        lb_speedup_enable})) else $error("control readback wrong");
    chk_status_read: assert property (s_pins_steady ##0 s_read_done |-> {reg_rdata[15:13],
        reg_rdata[4]} == {line_len_in, lb_detected_in}) else $error("status wrong");
    chk_write_ctl: assert property (wr_hit |=> {auto_crossover_enable, crossover_select,
        analog_loopback, lb_detect_enable, lb_speedup_enable} == wdata_r[9:5])
        else $error("write not applied");
    chk_reset_vals: assert property ($fell(rst) |-> {auto_crossover_enable, crossover_select,
        analog_loopback, lb_detect_enable, lb_speedup_enable} == 5'h18 && reg_rdata == 16'h0000)
        else $error("reset values wrong");
    chk_strap_load: assert property ($fell(rst) |=> rise_sel == $past(slew_config_pins, 2))
        else $error("strap not loaded");
    chk_xover_hold: assert property (!auto_crossover_enable && !wr_hit |=>
        $stable(crossover_select)) else $error("manual select moved");
    chk_xover_follow: assert property (s_auto_steady |-> crossover_select == xover_auto_in)
        else $error("auto select not followed");
endmodule : psf_reg_checker
`default_nettype wire

// ### verification/tb_top.sv
/* tb_top: random and corner register traffic for psf_reg, checked by readback.
   assumes psf_pkg, psf_reg and the checker are compiled before this file. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, reg_wr, reg_rd, lb_detected_in, xover_auto_in;
    logic        auto_crossover_enable, crossover_select, analog_loopback;
    logic        lb_detect_enable, lb_speedup_enable;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val, d;
    logic [1:0]  slew_config_pins, rise_sel;
    logic [2:0]  line_len_in;
    logic [5:0]  rise_time_dns;
    int          n_mismatch, comparisons;
    integer      seed;
    psf_reg i_psf_reg (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .slew_config_pins      (slew_config_pins),
        .line_len_in           (line_len_in),
        .lb_detected_in        (lb_detected_in),
        .xover_auto_in         (xover_auto_in),
        .rise_sel              (rise_sel),
        .rise_time_dns         (rise_time_dns),
        .auto_crossover_enable (auto_crossover_enable),
        .crossover_select      (crossover_select),
        .analog_loopback       (analog_loopback),
        .lb_detect_enable      (lb_detect_enable),
        .lb_speedup_enable     (lb_speedup_enable)
    );
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // tasks start just after an edge so strobes can run back to back
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        @(posedge clk_sys);
    endtask : rd
    function automatic logic [15:0] exp_word(input logic [15:0] v, input logic follow);
        logic [15:0] e;
        e = {line_len_in, 1'b0, v[11:5], lb_detected_in, 4'h0};
        if (follow && v[9]) e[8] = xover_auto_in;
        return e;
    endfunction : exp_word
    task automatic wrap_up();
        $display("n_mismatch=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 21'h00_0000};
        {slew_config_pins, line_len_in, lb_detected_in, xover_auto_in} = 7'h41;
        seed = 46839;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd(5'h1b);
        chk(rd_val, 16'h0b00);
        rd(5'h1a);
        chk(rd_val, 16'h0000);
        for (int i = 0; i < 40; i++) begin
            d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
            {line_len_in, lb_detected_in, xover_auto_in} <= {d[15:13], d[4], d[2]};
            repeat (6) @(posedge clk_sys);
            wr(5'h1b, d & 16'hefe0);
            rd(5'h1b);
            chk(rd_val, exp_word(d, 1'b0));
            chk({10'h000, rise_time_dns}, {10'h000, 6'h21 + 6'h03 * {4'h0, d[11:10]}});
            wr(5'h03, ~d);
            rd(5'h1b);
            chk(rd_val, exp_word(d, 1'b1));
        end
        slew_config_pins <= 2'h1;
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd(5'h1b);
        chk(rd_val, {line_len_in, 4'h3, xover_auto_in, 3'h0, lb_detected_in, 4'h0});
        wrap_up();
    end
endmodule : tb_top
bind psf_reg psf_reg_checker i_psf_reg_checker (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .slew_config_pins      (slew_config_pins),
    .rise_sel              (rise_sel),
    .line_len_in           (line_len_in),
    .lb_detected_in        (lb_detected_in),
    .xover_auto_in         (xover_auto_in),
    .auto_crossover_enable (auto_crossover_enable),
    .crossover_select      (crossover_select),
    .analog_loopback       (analog_loopback),
    .lb_detect_enable      (lb_detect_enable),
    .lb_speedup_enable     (lb_speedup_enable)
);
`default_nettype wire
